// [hdl/vef_pkg.sv]
// constants, register map and envelope tables for the voice/envelope/filter core
package vef_pkg;
  // register map, voice groups repeat every stride
  localparam int VEF_REG_COUNT = 25;
  localparam int VEF_VOICES = 3;
  localparam logic [4:0] VEF_VOICE_STRIDE = 5'h07;
  localparam logic [4:0] VEF_OFS_FREQ_LO = 5'h00;
  localparam logic [4:0] VEF_OFS_FREQ_HI = 5'h01;
  localparam logic [4:0] VEF_OFS_PW_LO = 5'h02;
  localparam logic [4:0] VEF_OFS_PW_HI = 5'h03;
  localparam logic [4:0] VEF_OFS_CTRL = 5'h04;
  localparam logic [4:0] VEF_OFS_ATTACK_DECAY = 5'h05;
  localparam logic [4:0] VEF_OFS_SUSTAIN_RELEASE = 5'h06;
  localparam logic [4:0] VEF_ADDR_CUTOFF_LOW = 5'h15;
  localparam logic [4:0] VEF_ADDR_CUTOFF_HIGH = 5'h16;
  localparam logic [4:0] VEF_ADDR_RES_ROUTE = 5'h17;
  localparam logic [4:0] VEF_ADDR_MODE_VOL = 5'h18;
  localparam logic [4:0] VEF_ADDR_OSC3_READ = 5'h1b;
  localparam logic [4:0] VEF_ADDR_ENV3_READ = 5'h1c;
  localparam logic [7:0] VEF_REG_RESET = 8'h00;
  // control register bits
  localparam int VEF_CTRL_GATE = 0;
  localparam int VEF_CTRL_SYNC = 1;
  localparam int VEF_CTRL_RING = 2;
  localparam int VEF_CTRL_TEST = 3;
  localparam int VEF_CTRL_TRI = 4;
  localparam int VEF_CTRL_SAW = 5;
  localparam int VEF_CTRL_PULSE = 6;
  localparam int VEF_CTRL_NOISE = 7;
  // mode register bits
  localparam int VEF_MODE_LOW_PASS = 4;
  localparam int VEF_MODE_BAND_PASS = 5;
  localparam int VEF_MODE_HIGH_PASS = 6;
  localparam int VEF_MODE_VOICE3_OFF = 7;
  // oscillator shape
  localparam int VEF_ACC_W = 24;
  localparam int VEF_WAVE_W = 12;
  localparam int VEF_NOISE_CLK_BIT = 19;
  localparam int VEF_LFSR_W = 23;
  localparam int VEF_LFSR_TAP = 17;
  localparam logic [11:0] VEF_WAVE_FULL = 12'hfff;
  localparam logic [7:0] VEF_ENV_PEAK = 8'hff;
  // envelope rate table, full-swing times in microseconds at the reference clock
  localparam int VEF_REF_CLK_MHZ = 1;
  localparam int VEF_ENV_STEPS = 255;
  localparam int VEF_FALL_FACTOR = 3;
  localparam int VEF_ATTACK_US [16] = '{2000, 8000, 16000, 24000, 38000, 56000,
    68000, 80000, 100000, 250000, 500000, 800000, 1000000, 3000000, 5000000,
    8000000};
  localparam int VEF_FALL_US [16] = '{6000, 24000, 48000, 72000, 114000,
    168000, 204000, 240000, 300000, 750000, 1500000, 2400000, 3000000,
    9000000, 15000000, 24000000};
  typedef enum logic [1:0] {
    VEF_ENV_ATTACK,
    VEF_ENV_DECAY,
    VEF_ENV_RELEASE
  } vef_env_state_t;
  // master clock cycles per envelope step for a rate code
  function automatic logic [16:0] vef_step_cycles(input logic [3:0] code,
                                                  input logic fall);
    int us;
    us = fall ? VEF_FALL_US[code] : VEF_ATTACK_US[code];
    return 17'((us * VEF_REF_CLK_MHZ) / VEF_ENV_STEPS);
  endfunction
endpackage

// [hdl/vef_env_gen.sv]
// one envelope generator: 8-bit amplitude counter with rate prescaler
`timescale 1ns/100ps
`default_nettype none
module vef_env_gen (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_gate,
  input wire logic [3:0] i_attack_rate_code,
  input wire logic [3:0] i_decay_rate_code,
  input wire logic [3:0] i_hold_level_code,
  input wire logic [3:0] i_release_rate_code,
  input wire logic [16:0] i_rate_div,
  output logic [7:0] o_level
);
  vef_pkg::vef_env_state_t state_reg, state_next;
  logic [7:0] level_reg, level_next;
  logic [16:0] pre_reg, pre_next;
  logic gate_reg, gate_next;
  logic [16:0] period;
  logic [7:0] target;

  assign o_level = level_reg;

  // next envelope state, level and prescaler
  always_comb begin
    state_next = state_reg;
    level_next = level_reg;
    pre_next = pre_reg + 17'h00001;
    gate_next = i_gate;
    target = {i_hold_level_code, i_hold_level_code};
    // R5 R6 R7 R8 R9 R10 R12 rate chosen per phase
    case (state_reg)
      vef_pkg::VEF_ENV_ATTACK: period = vef_pkg::vef_step_cycles(i_attack_rate_code, 1'b0);
      vef_pkg::VEF_ENV_DECAY: period = vef_pkg::vef_step_cycles(i_decay_rate_code, 1'b1);
      default: period = vef_pkg::vef_step_cycles(i_release_rate_code, 1'b1);
    endcase
    period = period / i_rate_div;
    if (period == 17'h00000) begin
      period = 17'h00001;
    end
    // R13 R22 gate edges restart from current amplitude
    if (i_gate && !gate_reg) begin
      state_next = vef_pkg::VEF_ENV_ATTACK;
      pre_next = 17'h00000;
    end else if (!i_gate && gate_reg) begin
      state_next = vef_pkg::VEF_ENV_RELEASE;
      pre_next = 17'h00000;
    end else if (pre_next >= period) begin
      // R25 one amplitude step per prescaler period
      pre_next = 17'h00000;
      case (state_reg)
        vef_pkg::VEF_ENV_ATTACK: begin
          // R6 decay starts on the step that reaches peak
          if (level_reg != vef_pkg::VEF_ENV_PEAK) begin
            level_next = level_reg + 8'h01;
          end
          if (level_next == vef_pkg::VEF_ENV_PEAK) begin
            state_next = vef_pkg::VEF_ENV_DECAY;
          end
        end
        vef_pkg::VEF_ENV_DECAY: begin
          // R11 hold at sustain level
          if (level_reg > target) begin
            level_next = level_reg - 8'h01;
          end
        end
        default: begin
          if (level_reg != 8'h00) begin
            level_next = level_reg - 8'h01;
          end
        end
      endcase
    end
  end

  // envelope registers
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg <= vef_pkg::VEF_ENV_RELEASE;
      level_reg <= 8'h00;
      pre_reg <= 17'h00000;
      gate_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      level_reg <= level_next;
      pre_reg <= pre_next;
      gate_reg <= gate_next;
    end
  end

  property p_gate_rise_attack;
    @(posedge i_core_clk) disable iff (!i_reset_n)
      (i_gate && !gate_reg) |=> (state_reg == vef_pkg::VEF_ENV_ATTACK) && $stable(level_reg);
  endproperty
  a_gate_rise_attack: assert property (p_gate_rise_attack) // R13
    else $error("gate rise did not restart attack from level");

  property p_gate_fall_release;
    @(posedge i_core_clk) disable iff (!i_reset_n)
      (!i_gate && gate_reg) |=> state_reg == vef_pkg::VEF_ENV_RELEASE;
  endproperty
  a_gate_fall_release: assert property (p_gate_fall_release) // R12
    else $error("gate fall did not start release");

  property p_attack_rises;
    @(posedge i_core_clk) disable iff (!i_reset_n)
      (state_reg == vef_pkg::VEF_ENV_ATTACK && i_gate && gate_reg)
        |=> level_reg >= $past(level_reg);
  endproperty
  a_attack_rises: assert property (p_attack_rises) // R5
    else $error("level fell during attack");

  property p_hold_floor;
    @(posedge i_core_clk) disable iff (!i_reset_n)
      (state_reg == vef_pkg::VEF_ENV_DECAY && level_reg >= target && i_gate && gate_reg)
        |=> level_reg >= $past(target);
  endproperty
  a_hold_floor: assert property (p_hold_floor) // R11
    else $error("decay went below sustain level");

  property p_step_spacing;
    @(posedge i_core_clk) disable iff (!i_reset_n)
      pre_reg <= vef_pkg::vef_step_cycles(4'hf, 1'b1);
  endproperty
  a_step_spacing: assert property (p_step_spacing) // R25
    else $error("prescaler ran past longest period");
endmodule
`default_nettype wire

// [hdl/vef_core.sv]
// three-voice waveform, envelope and filter control core
// Notes on behaviour
// R1 - noise steps at its oscillator's rate
// R2 - voice level scaled only by envelope
// R3 - several waveforms combine by bitwise AND
// R4 - noise plus other waveform locks noise silent
// R5 - attack code is bits 4-7
// R6 - decay code is bits 0-3
// R7 - attack times 2 ms to 8 s
// R8 - decay and release share 6 ms-24 s table
// R9 - rates counted in master clock cycles
// R10 - each rate is a full swing
// R11 - hold level code in bits 4-7
// R12 - gate clear falls to zero at release
// R13 - gate edges restart from current amplitude
// R14 - three identical seven-register voice groups
// R15 - sync and ring source rotates 3,1,2
// R16 - cutoff is 11 bits, low byte 3
// R17 - peaking level in bits 4-7
// R18 - routing bits 0-3 voice1,2,3,external
// R19 - mode bits 4,5,6 select filter outputs
// R20 - no waveform selected gives no output
// R21 - host paces gate toggling
// R22 - control bit 0 is the gate
// R23 - test bit holds oscillator and noise reset
// R24 - reset clears all registers, output silent
// R25 - envelope is prescaled 8-bit counter
`timescale 1ns/100ps
`default_nettype none
module vef_core #(
  parameter logic [16:0] RATE_DIV = 17'h00001
) (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_chip_select_n,
  input wire logic i_bus_phase,
  input wire logic i_read_not_write,
  input wire logic [4:0] i_addr,
  input wire logic [7:0] i_data,
  output logic [7:0] o_data,
  output logic o_data_oe_n,
  output logic [11:0] o_voice1_amp,
  output logic [11:0] o_voice2_amp,
  output logic [11:0] o_voice3_amp,
  output logic [10:0] o_filter_cutoff_value,
  output logic [3:0] o_filter_peaking_level,
  output logic [3:0] o_filter_route,
  output logic o_low_pass_select,
  output logic o_band_pass_select,
  output logic o_high_pass_select,
  output logic o_voice3_off,
  output logic [3:0] o_volume
);
  localparam int NV = vef_pkg::VEF_VOICES;
  localparam int AW = vef_pkg::VEF_ACC_W;
  localparam int WW = vef_pkg::VEF_WAVE_W;

  logic [7:0] regs_reg [vef_pkg::VEF_REG_COUNT];
  logic [7:0] regs_next [vef_pkg::VEF_REG_COUNT];
  logic [AW-1:0] acc_reg [NV];
  logic [AW-1:0] acc_next [NV];
  logic [AW-1:0] acc_inc [NV];
  logic [vef_pkg::VEF_LFSR_W-1:0] lfsr_reg [NV];
  logic [vef_pkg::VEF_LFSR_W-1:0] lfsr_next [NV];
  logic lock_reg [NV];
  logic lock_next [NV];
  logic [WW-1:0] amp_reg [NV];
  logic [WW-1:0] amp_next [NV];
  logic [WW-1:0] wave [NV];
  logic [7:0] env [NV];
  logic [7:0] data_reg, data_next;
  logic oe_n_reg, oe_n_next;
  logic wr_strobe, rd_strobe;

  // address of a register inside a voice group
  function automatic logic [4:0] voice_addr(input int v, input logic [4:0] ofs);
    return 5'(v * vef_pkg::VEF_VOICE_STRIDE) + ofs;
  endfunction

  // voice that feeds sync and ring of voice v
  function automatic int mod_source(input int v);
    return (v + NV - 1) % NV;
  endfunction

  // control byte of voice v
  function automatic logic [7:0] ctrl_of(input int v);
    return regs_reg[voice_addr(v, vef_pkg::VEF_OFS_CTRL)];
  endfunction

  assign wr_strobe = !i_chip_select_n && i_bus_phase && !i_read_not_write;
  assign rd_strobe = !i_chip_select_n && i_bus_phase && i_read_not_write;

  // register writes, unmapped addresses ignored
  always_comb begin
    for (int a = 0; a < vef_pkg::VEF_REG_COUNT; a++) begin
      regs_next[a] = regs_reg[a];
    end
    // R14 one decode serves every voice group
    if (wr_strobe && i_addr < 5'(vef_pkg::VEF_REG_COUNT)) begin
      regs_next[i_addr] = i_data;
    end
  end

  // register file
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      // R24 everything clears to zero
      for (int a = 0; a < vef_pkg::VEF_REG_COUNT; a++) begin
        regs_reg[a] <= vef_pkg::VEF_REG_RESET;
      end
    end else begin
      for (int a = 0; a < vef_pkg::VEF_REG_COUNT; a++) begin
        regs_reg[a] <= regs_next[a];
      end
    end
  end

  // read port, oscillator 3 and envelope 3 readback
  always_comb begin
    data_next = 8'h00;
    oe_n_next = !rd_strobe;
    if (i_addr == vef_pkg::VEF_ADDR_OSC3_READ) begin
      data_next = wave[NV-1][WW-1:WW-8];
    end else if (i_addr == vef_pkg::VEF_ADDR_ENV3_READ) begin
      data_next = env[NV-1];
    end else begin
      data_next = 8'h00;
    end
  end

  // read data registers
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      data_reg <= 8'h00;
      oe_n_reg <= 1'b1;
    end else begin
      data_reg <= data_next;
      oe_n_reg <= oe_n_next;
    end
  end

  // envelope generators, one per voice
  for (genvar g = 0; g < NV; g++) begin : g_env
    vef_env_gen u_env (
      .i_core_clk(i_core_clk),
      .i_reset_n(i_reset_n),
      // R22 gate is control bit 0
      .i_gate(regs_reg[voice_addr(g, vef_pkg::VEF_OFS_CTRL)][vef_pkg::VEF_CTRL_GATE]),
      .i_attack_rate_code(regs_reg[voice_addr(g, vef_pkg::VEF_OFS_ATTACK_DECAY)][7:4]),
      .i_decay_rate_code(regs_reg[voice_addr(g, vef_pkg::VEF_OFS_ATTACK_DECAY)][3:0]),
      .i_hold_level_code(regs_reg[voice_addr(g, vef_pkg::VEF_OFS_SUSTAIN_RELEASE)][7:4]),
      .i_release_rate_code(regs_reg[voice_addr(g, vef_pkg::VEF_OFS_SUSTAIN_RELEASE)][3:0]),
      .i_rate_div(RATE_DIV),
      .o_level(env[g])
    );
  end

  // waveform shaping from present oscillator state
  always_comb begin
    for (int v = 0; v < NV; v++) begin
      logic [7:0] c;
      logic [AW-1:0] a;
      logic msb;
      logic [WW-1:0] pw;
      logic [WW-1:0] tri_w;
      logic [WW-1:0] pul_w;
      logic [WW-1:0] noi_w;
      logic [vef_pkg::VEF_LFSR_W-1:0] n;
      c = ctrl_of(v);
      a = acc_reg[v];
      n = lfsr_reg[v];
      pw = {regs_reg[voice_addr(v, vef_pkg::VEF_OFS_PW_HI)][3:0],
            regs_reg[voice_addr(v, vef_pkg::VEF_OFS_PW_LO)]};
      // R15 ring modulation takes the rotated source msb
      msb = a[AW-1] ^ (c[vef_pkg::VEF_CTRL_RING] & acc_reg[mod_source(v)][AW-1]);
      tri_w = msb ? ~a[AW-2:AW-1-WW] : a[AW-2:AW-1-WW];
      pul_w = (c[vef_pkg::VEF_CTRL_TEST] || a[AW-1:AW-WW] >= pw) ?
              vef_pkg::VEF_WAVE_FULL : 12'h000;
      noi_w = {n[22], n[20], n[16], n[13], n[11], n[7], n[4], n[2], 4'h0};
      // R4 a locked noise generator stays silent
      if (lock_reg[v]) begin
        noi_w = 12'h000;
      end
      // R3 selected waveforms are ANDed together
      wave[v] = vef_pkg::VEF_WAVE_FULL;
      if (c[vef_pkg::VEF_CTRL_TRI]) begin
        wave[v] = wave[v] & tri_w;
      end
      if (c[vef_pkg::VEF_CTRL_SAW]) begin
        wave[v] = wave[v] & a[AW-1:AW-WW];
      end
      if (c[vef_pkg::VEF_CTRL_PULSE]) begin
        wave[v] = wave[v] & pul_w;
      end
      if (c[vef_pkg::VEF_CTRL_NOISE]) begin
        wave[v] = wave[v] & noi_w;
      end
      // R20 nothing selected gives nothing
      if (c[7:4] == 4'h0) begin
        wave[v] = 12'h000;
      end
    end
  end

  // oscillator, noise and amplitude next values
  always_comb begin
    for (int v = 0; v < NV; v++) begin
      acc_inc[v] = acc_reg[v] + AW'({regs_reg[voice_addr(v, vef_pkg::VEF_OFS_FREQ_HI)],
                                     regs_reg[voice_addr(v, vef_pkg::VEF_OFS_FREQ_LO)]});
    end
    for (int v = 0; v < NV; v++) begin
      logic [7:0] c;
      logic [19:0] prod;
      logic src_wrap;
      logic noise_clk;
      c = ctrl_of(v);
      src_wrap = !acc_reg[mod_source(v)][AW-1] && acc_inc[mod_source(v)][AW-1];
      noise_clk = !acc_reg[v][vef_pkg::VEF_NOISE_CLK_BIT] &&
                  acc_inc[v][vef_pkg::VEF_NOISE_CLK_BIT];
      acc_next[v] = acc_inc[v];
      lfsr_next[v] = lfsr_reg[v];
      lock_next[v] = lock_reg[v];
      // R15 hard sync from the rotated source
      if (c[vef_pkg::VEF_CTRL_SYNC] && src_wrap) begin
        acc_next[v] = '0;
      end
      // R1 noise shifts when its oscillator crosses the noise bit
      if (noise_clk) begin
        lfsr_next[v] = {lfsr_reg[v][vef_pkg::VEF_LFSR_W-2:0],
                        ~(lfsr_reg[v][vef_pkg::VEF_LFSR_W-1] ^
                          lfsr_reg[v][vef_pkg::VEF_LFSR_TAP])};
        // R4 mixing noise with another waveform locks it
        if (c[vef_pkg::VEF_CTRL_NOISE] && c[6:4] != 3'h0) begin
          lock_next[v] = 1'b1;
        end
      end
      // R23 test holds oscillator and noise at zero
      if (c[vef_pkg::VEF_CTRL_TEST]) begin
        acc_next[v] = '0;
        lfsr_next[v] = '0;
        lock_next[v] = 1'b0;
      end
      // R2 amplitude follows the envelope only
      prod = wave[v] * env[v];
      amp_next[v] = prod[19:8];
    end
  end

  // oscillator state and voice outputs
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int v = 0; v < NV; v++) begin
        acc_reg[v] <= '0;
        lfsr_reg[v] <= '0;
        lock_reg[v] <= 1'b0;
        amp_reg[v] <= 12'h000;
      end
    end else begin
      for (int v = 0; v < NV; v++) begin
        acc_reg[v] <= acc_next[v];
        lfsr_reg[v] <= lfsr_next[v];
        lock_reg[v] <= lock_next[v];
        amp_reg[v] <= amp_next[v];
      end
    end
  end

  // outputs taken straight from registers
  assign o_data = data_reg;
  assign o_data_oe_n = oe_n_reg;
  assign o_voice1_amp = amp_reg[0];
  assign o_voice2_amp = amp_reg[1];
  assign o_voice3_amp = amp_reg[2];
  // R16 cutoff uses low bits 0-2 only
  assign o_filter_cutoff_value = {regs_reg[vef_pkg::VEF_ADDR_CUTOFF_HIGH],
                                  regs_reg[vef_pkg::VEF_ADDR_CUTOFF_LOW][2:0]};
  // R17 R18 peaking level and routing
  assign o_filter_peaking_level = regs_reg[vef_pkg::VEF_ADDR_RES_ROUTE][7:4];
  assign o_filter_route = regs_reg[vef_pkg::VEF_ADDR_RES_ROUTE][3:0];
  // R19 filter output selects
  assign o_low_pass_select = regs_reg[vef_pkg::VEF_ADDR_MODE_VOL][vef_pkg::VEF_MODE_LOW_PASS];
  assign o_band_pass_select = regs_reg[vef_pkg::VEF_ADDR_MODE_VOL][vef_pkg::VEF_MODE_BAND_PASS];
  assign o_high_pass_select = regs_reg[vef_pkg::VEF_ADDR_MODE_VOL][vef_pkg::VEF_MODE_HIGH_PASS];
  assign o_voice3_off = regs_reg[vef_pkg::VEF_ADDR_MODE_VOL][vef_pkg::VEF_MODE_VOICE3_OFF];
  assign o_volume = regs_reg[vef_pkg::VEF_ADDR_MODE_VOL][3:0];

  property p_silent_at_zero_env;
    @(posedge i_core_clk) disable iff (!i_reset_n)
      env[0] == 8'h00 |=> o_voice1_amp == 12'h000;
  endproperty
  a_silent_at_zero_env: assert property (p_silent_at_zero_env) // R2
    else $error("voice audible with zero envelope");

  property p_no_wave_silent;
    @(posedge i_core_clk) disable iff (!i_reset_n)
      regs_reg[voice_addr(0, vef_pkg::VEF_OFS_CTRL)][7:4] == 4'h0 |=> o_voice1_amp == 12'h000;
  endproperty
  a_no_wave_silent: assert property (p_no_wave_silent) // R20
    else $error("voice heard with no waveform selected");

  property p_test_clears_lock;
    @(posedge i_core_clk) disable iff (!i_reset_n)
      regs_reg[voice_addr(2, vef_pkg::VEF_OFS_CTRL)][vef_pkg::VEF_CTRL_TEST]
        |=> !lock_reg[2] && acc_reg[2] == '0;
  endproperty
  a_test_clears_lock: assert property (p_test_clears_lock) // R23
    else $error("test bit did not clear oscillator");

  property p_cutoff_write;
    @(posedge i_core_clk) disable iff (!i_reset_n)
      (wr_strobe && i_addr == vef_pkg::VEF_ADDR_CUTOFF_LOW)
        |=> o_filter_cutoff_value[2:0] == $past(i_data[2:0]);
  endproperty
  a_cutoff_write: assert property (p_cutoff_write) // R16
    else $error("cutoff low bits not taken");

  property p_route_write;
    @(posedge i_core_clk) disable iff (!i_reset_n)
      (wr_strobe && i_addr == vef_pkg::VEF_ADDR_RES_ROUTE)
        |=> o_filter_route == $past(i_data[3:0]) ##1 $stable(o_filter_peaking_level) || wr_strobe;
  endproperty
  a_route_write: assert property (p_route_write) // R18
    else $error("routing bits not taken");
endmodule
`default_nettype wire

// [tb/vef_host_model.sv]
// host model: bus master writing and reading the core registers
`timescale 1ns/100ps
`default_nettype none
module vef_host_model (
  input wire logic i_core_clk,
  input wire logic [7:0] i_rd_data,
  input wire logic i_rd_oe_n,
  output logic o_cs_n,
  output logic o_phase,
  output logic o_rnw,
  output logic [4:0] o_addr,
  output logic [7:0] o_data
);
  // idle bus from time zero
  initial begin
    o_cs_n = 1'b1;
    o_phase = 1'b0;
    o_rnw = 1'b1;
    o_addr = 5'h1f;
    o_data = 8'h00;
  end
  task automatic write_reg(input logic [4:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    o_cs_n <= 1'b0;
    o_phase <= 1'b1;
    o_rnw <= 1'b0;
    o_addr <= a;
    o_data <= d;
    @(posedge i_core_clk);
    o_cs_n <= 1'b1;
    o_phase <= 1'b0;
    o_rnw <= 1'b1;
    o_data <= ~d;  // released pins lose the value
  endtask
  // read held until a cycle after the core drives the data pins, or for at most five cycles
  task automatic read_reg(input logic [4:0] a, output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d = 8'h00;
    @(posedge i_core_clk);
    o_cs_n <= 1'b0;
    o_phase <= 1'b1;
    o_rnw <= 1'b1;
    o_addr <= a;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge i_core_clk);
      #1;
      if (i_rd_oe_n === 1'b0) begin
        ok = 1'b1;
        d = i_rd_data;
      end
    end
    @(posedge i_core_clk);
    o_cs_n <= 1'b1;
    o_phase <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [tb/vef_core_tb_top.sv]
// self-checking bench for the voice, envelope and filter core
`timescale 1ns/100ps
`default_nettype none
module vef_core_tb_top;
  localparam logic [16:0] DIV = 17'h00010;
  localparam logic [4:0] V3 = vef_pkg::VEF_VOICE_STRIDE + vef_pkg::VEF_VOICE_STRIDE;
  logic i_core_clk, i_reset_n, cs_n, phase, rnw, oe_n, lp, bp, hp, v3off, ok;
  logic [4:0] addr;
  logic [7:0] wdata, rdata, v, a, b, c;
  logic [11:0] amp1, amp2, amp3;
  logic [10:0] cutoff;
  logic [3:0] peak, route, vol;
  int failures, cmp_count, t0;
  int cyc = 0;
  vef_core #(.RATE_DIV(DIV)) u_vef_core (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
    .i_chip_select_n(cs_n), .i_bus_phase(phase), .i_read_not_write(rnw), .i_addr(addr),
    .i_data(wdata), .o_data(rdata), .o_data_oe_n(oe_n), .o_voice1_amp(amp1),
    .o_voice2_amp(amp2), .o_voice3_amp(amp3), .o_filter_cutoff_value(cutoff),
    .o_filter_peaking_level(peak), .o_filter_route(route), .o_low_pass_select(lp),
    .o_band_pass_select(bp), .o_high_pass_select(hp), .o_voice3_off(v3off), .o_volume(vol));
  vef_host_model u_vef_host_model (.i_core_clk(i_core_clk), .i_rd_data(rdata),
    .i_rd_oe_n(oe_n), .o_cs_n(cs_n), .o_phase(phase), .o_rnw(rnw), .o_addr(addr),
    .o_data(wdata));
  // clock and cycle count
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  always @(posedge i_core_clk) cyc <= cyc + 1;
  task automatic final_report();
    $display("summary: %0d comparisons, %0d failures", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // elapsed cycles against an expectation with a tolerance
  task automatic near(input int got, input int exp, input int tol);
    cmp_count++;
    if (got < exp - tol || got > exp + tol) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] ad, input logic [7:0] d);
    u_vef_host_model.write_reg(ad, d);
    #1;
  endtask
  task automatic rd(input logic [4:0] ad);
    u_vef_host_model.read_reg(ad, v, ok);
    if (ok !== 1'b1) begin
      check(ok, 1'b1);
      final_report();
    end
  endtask
  // poll the voice 3 envelope until it shows the target
  task automatic wait_env(input logic [7:0] tgt, input int bound);
    for (int i = 0; i < bound; i++) begin
      rd(vef_pkg::VEF_ADDR_ENV3_READ);
      if (v === tgt) return;
    end
    check(v, tgt);
    final_report();
  endtask
  function automatic int step_of(input int us);
    int s;
    s = us * vef_pkg::VEF_REF_CLK_MHZ / vef_pkg::VEF_ENV_STEPS / int'(DIV);
    return (s < 1) ? 1 : s;
  endfunction
  // overall hang guard
  initial begin
    repeat (100000) @(posedge i_core_clk);
    failures++;
    final_report();
  end
  // main sequence
  initial begin
    failures = 0;
    cmp_count = 0;
    i_reset_n = 1'b0;
    repeat (12) @(posedge i_core_clk);
    i_reset_n <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    #1;
    check({amp1, amp2, amp3, cutoff, peak, route, lp, bp, hp, v3off, vol, oe_n}, 64'h1);
    rd(vef_pkg::VEF_ADDR_ENV3_READ);
    check(v, 8'h00);
    $display("test reset done");
    // filter fields, mode bits and an unmapped write
    wr(vef_pkg::VEF_ADDR_CUTOFF_LOW, 8'hff);
    wr(vef_pkg::VEF_ADDR_CUTOFF_HIGH, 8'ha5);
    check(cutoff, {8'ha5, 3'h7});
    wr(vef_pkg::VEF_ADDR_RES_ROUTE, 8'h5a);
    check({peak, route}, 8'h5a);
    for (int k = 4; k < 7; k++) begin
      wr(vef_pkg::VEF_ADDR_MODE_VOL, 8'(1 << k) | 8'h83);
      check({lp, bp, hp, v3off, vol}, {3'b100 >> (k - 4), 1'b1, 4'h3});
    end
    wr(5'h19, 8'h00);
    check({cutoff, peak, route}, {8'ha5, 3'h7, 8'h5a});
    rd(5'h1a);
    check(v, 8'h00);
    $display("test filter done");
    // voice 1 held by test bit, pulse full, envelope at peak
    wr(vef_pkg::VEF_OFS_ATTACK_DECAY, 8'h00);
    wr(vef_pkg::VEF_OFS_SUSTAIN_RELEASE, 8'hf0);
    wr(vef_pkg::VEF_OFS_CTRL, 8'h49);
    repeat (600) @(posedge i_core_clk);
    #1;
    check(amp1, 12'((24'(vef_pkg::VEF_WAVE_FULL) * 24'(vef_pkg::VEF_ENV_PEAK)) >> 8));
    wr(vef_pkg::VEF_OFS_CTRL, 8'h69);
    repeat (4) @(posedge i_core_clk);
    #1;
    check(amp1, 12'h000);
    wr(vef_pkg::VEF_OFS_CTRL, 8'h09);
    repeat (4) @(posedge i_core_clk);
    #1;
    check(amp1, 12'h000);
    wr(vef_pkg::VEF_OFS_CTRL, 8'h48);
    repeat (600) @(posedge i_core_clk);
    #1;
    check(amp1, 12'h000);
    wr(V3 + vef_pkg::VEF_OFS_CTRL, 8'h48);
    rd(vef_pkg::VEF_ADDR_OSC3_READ);
    check({v, amp3}, {8'hff, 12'h000});
    $display("test waveform done");
    // voice 3 envelope timing through attack, decay, sustain, release
    wr(V3 + vef_pkg::VEF_OFS_ATTACK_DECAY, 8'h82);
    wr(V3 + vef_pkg::VEF_OFS_SUSTAIN_RELEASE, 8'h81);
    wr(V3 + vef_pkg::VEF_OFS_CTRL, 8'h41);
    t0 = cyc;
    wait_env(8'hff, 3000);
    near(cyc - t0, 255 * step_of(vef_pkg::VEF_ATTACK_US[8]), 32);
    t0 = cyc;
    wait_env(8'h88, 1000);
    near(cyc - t0, 119 * step_of(vef_pkg::VEF_FALL_US[2]), 20);
    repeat (500) @(posedge i_core_clk);
    rd(vef_pkg::VEF_ADDR_ENV3_READ);
    check(v, 8'h88);
    wr(V3 + vef_pkg::VEF_OFS_CTRL, 8'h40);
    t0 = cyc;
    wait_env(8'h00, 1000);
    near(cyc - t0, 136 * step_of(vef_pkg::VEF_FALL_US[1]), 16);
    $display("test envelope done");
    // gate cleared mid attack, then set again mid release
    wr(V3 + vef_pkg::VEF_OFS_CTRL, 8'h41);
    repeat (1200) @(posedge i_core_clk);
    rd(vef_pkg::VEF_ADDR_ENV3_READ);
    b = v;
    wr(V3 + vef_pkg::VEF_OFS_CTRL, 8'h40);
    repeat (40) @(posedge i_core_clk);
    rd(vef_pkg::VEF_ADDR_ENV3_READ);
    a = v;
    check(a < b, 1'b1);
    wr(V3 + vef_pkg::VEF_OFS_CTRL, 8'h41);
    rd(vef_pkg::VEF_ADDR_ENV3_READ);
    c = v;
    check(c > 8'h00, 1'b1);
    repeat (200) @(posedge i_core_clk);
    rd(vef_pkg::VEF_ADDR_ENV3_READ);
    check(v > c, 1'b1);
    $display("test retrigger done");
    // voice 3 noise readback, lock-up and recovery by test bit
    wr(V3 + vef_pkg::VEF_OFS_FREQ_LO, 8'hff);
    wr(V3 + vef_pkg::VEF_OFS_FREQ_HI, 8'hff);
    wr(V3 + vef_pkg::VEF_OFS_CTRL, 8'h88);
    wr(V3 + vef_pkg::VEF_OFS_CTRL, 8'h80);
    repeat (400) @(posedge i_core_clk);
    rd(vef_pkg::VEF_ADDR_OSC3_READ);
    a = v;
    repeat (48) @(posedge i_core_clk);
    rd(vef_pkg::VEF_ADDR_OSC3_READ);
    check(v != a, 1'b1);
    wr(V3 + vef_pkg::VEF_OFS_CTRL, 8'hc0);
    repeat (48) @(posedge i_core_clk);
    wr(V3 + vef_pkg::VEF_OFS_CTRL, 8'h80);
    repeat (48) @(posedge i_core_clk);
    rd(vef_pkg::VEF_ADDR_OSC3_READ);
    check(v, 8'h00);
    wr(V3 + vef_pkg::VEF_OFS_CTRL, 8'h88);
    wr(V3 + vef_pkg::VEF_OFS_CTRL, 8'h80);
    repeat (400) @(posedge i_core_clk);
    rd(vef_pkg::VEF_ADDR_OSC3_READ);
    check(v != 8'h00, 1'b1);
    $display("test noise done");
    final_report();
  end
endmodule
`default_nettype wire
